// ===== include/usb_out_pkg.sv
package usb_out_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_LOW_OFF = 8'h14;
  localparam logic [7:0] CTRL_HIGH_OFF = 8'h15;
  localparam logic [7:0] COUNT_LOW_OFF = 8'h16;
  localparam logic [7:0] COUNT_HIGH_OFF = 8'h17;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int READY_BIT = 0;
  localparam int FULL_BIT = 1;
  localparam int OVERRUN_BIT = 2;
  localparam int DATA_ERROR_BIT = 3;
  localparam int FLUSH_BIT = 4;
  localparam int SEND_STALL_BIT = 5;
  localparam int STALL_SENT_BIT = 6;
  localparam int CLEAR_TOGGLE_BIT = 7;
  localparam int ISO_BIT = 6;
  localparam int DOUBLE_BUF_BIT = 7;
  localparam int COUNT_W = 10;
  localparam int COUNT_LOW_W = 8;
  localparam int COUNT_HIGH_W = 2;
  localparam int MAX_SLOTS = 2;
  typedef enum logic [1:0] {
    HS_ACK = 2'b00,
    HS_NAK = 2'b01,
    HS_STALL = 2'b10,
    HS_NONE = 2'b11
  } handshake_e;
endpackage : usb_out_pkg

// ===== src/usb_out_slot.sv
`timescale 1ns/100ps
// One packet slot: holds byte count and error flag of a stored packet.
module usb_out_slot
  import usb_out_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic load,
  input wire logic release_,
  input wire logic [usb_out_pkg::COUNT_W-1:0] countIn,
  input wire logic errorIn,
  output logic full,
  output logic [usb_out_pkg::COUNT_W-1:0] count,
  output logic error
);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      full <= 1'b0;
      count <= '0;
      error <= 1'b0;
    end else if (load) begin
      full <= 1'b1;
      count <= countIn;
      error <= errorIn;
    end else if (release_) begin
      full <= 1'b0;
    end
  end
endmodule : usb_out_slot

// ===== src/usb_out_endpoint_control.sv
`timescale 1ns/100ps
module usb_out_endpoint_control
  import usb_out_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [usb_out_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic packetDone,
  input wire logic [usb_out_pkg::COUNT_W-1:0] packetCount,
  input wire logic packetError,
  input wire logic outToken,
  input wire logic dataToggleIn,
  output logic [1:0] handshake,
  output logic dataToggle,
  output logic fifoPointerReset,
  output logic releasePacket,
  input wire logic intEnable,
  output logic intPulse
);
  import usb_out_pkg::*;

  logic packetReady_reg;
  logic overrun_reg;
  logic sendStall_reg;
  logic stallSent_reg;
  logic flush_reg;
  logic isoMode_reg;
  logic doubleBuf_reg;
  logic dataToggle_reg;
  logic head_reg;
  logic tail_reg;
  logic [7:0] rdData_reg;
  logic [MAX_SLOTS-1:0] slotFull;
  logic [COUNT_W-1:0] slotCount [MAX_SLOTS];
  logic [MAX_SLOTS-1:0] slotError;
  logic [MAX_SLOTS-1:0] slotLoad;
  logic [MAX_SLOTS-1:0] slotRelease;
  logic fifoFull;
  logic stallActive;
  logic acceptPacket;
  logic dropPacket;
  logic wrLow;
  logic wrHigh;
  logic fwClearReady;
  logic unload;
  logic reassert;
  logic [1:0] usedSlots;
  logic [COUNT_W-1:0] curCount;
  logic curError;
  logic intReady;
  logic intOverrun;
  logic intStall;
  logic [7:0] ctrlLowWord;
  logic [7:0] ctrlHighWord;
  logic [7:0] countLowWord;
  logic [7:0] countHighWord;
  logic [COUNT_HIGH_W-1:0] countHighBits;

  assign wrLow = regWrite && (regAddr == CTRL_LOW_OFF);
  assign wrHigh = regWrite && (regAddr == CTRL_HIGH_OFF);
  assign usedSlots = {1'b0, slotFull[0]} + {1'b0, slotFull[1]};

  // Full depends on the buffering mode, so toggling it changes the reading at once.
  assign fifoFull = doubleBuf_reg ? (usedSlots == 2'd2) : (usedSlots != 2'd0);

  // Stall is ignored in isochronous mode.
  assign stallActive = sendStall_reg && !isoMode_reg;

  // Bulk packets with errors reach this block but are refused and never stored; only isochronous
  // traffic carries a flagged packet into the buffer.
  assign acceptPacket = packetDone && !stallActive && !fifoFull
                        && (isoMode_reg || !packetError);
  assign dropPacket = packetDone && !stallActive && fifoFull;

  // A clear with no packet ready is ignored, so a stray write cannot move the head.
  assign fwClearReady = wrLow && !regWrData[READY_BIT] && packetReady_reg;
  assign unload = fwClearReady || (flush_reg && packetReady_reg);
  assign releasePacket = unload;
  assign fifoPointerReset = flush_reg;

  always_comb begin
    slotLoad = '0;
    slotRelease = '0;
    slotLoad[tail_reg] = acceptPacket;
    slotRelease[head_reg] = unload;
  end

  // Each slot keeps the count and error flag of one packet. The bytes sit in the
  // shared endpoint memory outside this block, addressed by the pointer that
  // fifoPointerReset rewinds.
  genvar gi;
  generate
    for (gi = 0; gi < MAX_SLOTS; gi++) begin : gSlot
      usb_out_slot slot (
        .clock(clock),
        .nrst(nrst),
        .load(slotLoad[gi]),
        .release_(slotRelease[gi]),
        .countIn(packetCount),
        .errorIn(packetError && isoMode_reg),
        .full(slotFull[gi]),
        .count(slotCount[gi]),
        .error(slotError[gi])
      );
    end
  endgenerate

  assign curCount = slotCount[head_reg];
  assign curError = slotError[head_reg] && isoMode_reg;

  // In single buffering neither pointer moves, so only the slot they rest on is used.
  // Changing the buffering mode while packets are held leaves the pointers as they are.

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tail_reg <= 1'b0;
    end else if (acceptPacket) begin
      tail_reg <= doubleBuf_reg ? ~tail_reg : tail_reg;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      head_reg <= 1'b0;
    end else if (unload) begin
      head_reg <= doubleBuf_reg ? ~head_reg : head_reg;
    end
  end

  // Packet-ready follows the head slot: a second held packet raises it again
  // in the cycle after the clear.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      packetReady_reg <= 1'b0;
    end else if (unload) begin
      packetReady_reg <= 1'b0;
    end else if (!packetReady_reg && slotFull[head_reg]) begin
      packetReady_reg <= 1'b1;
    end
  end

  assign reassert = !packetReady_reg && slotFull[head_reg] && !unload;

  // Each source is one cycle wide: reassert drops as soon as packet-ready is
  // registered, and the drop and stall events are strobes themselves.
  assign intReady = slotFull[head_reg] && reassert;
  assign intOverrun = dropPacket && isoMode_reg;
  assign intStall = outToken && stallActive;

  // Hardware set wins over a firmware clear in the same cycle.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      overrun_reg <= 1'b0;
    end else if (dropPacket && isoMode_reg) begin
      overrun_reg <= 1'b1;
    end else if (wrLow && !regWrData[OVERRUN_BIT]) begin
      overrun_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stallSent_reg <= 1'b0;
    end else if (outToken && stallActive) begin
      stallSent_reg <= 1'b1;
    end else if (wrLow && !regWrData[STALL_SENT_BIT]) begin
      stallSent_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sendStall_reg <= 1'b0;
    end else if (wrLow) begin
      sendStall_reg <= regWrData[SEND_STALL_BIT];
    end
  end

  // Flush takes one cycle; firmware sees it set for at most one read.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flush_reg <= 1'b0;
    end else if (wrLow && regWrData[FLUSH_BIT]) begin
      flush_reg <= 1'b1;
    end else begin
      flush_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      isoMode_reg <= 1'b0;
      doubleBuf_reg <= 1'b0;
    end else if (wrHigh) begin
      isoMode_reg <= regWrData[ISO_BIT];
      doubleBuf_reg <= regWrData[DOUBLE_BUF_BIT];
    end
  end

  // The toggle flips on each accepted bulk packet with a matching toggle.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dataToggle_reg <= 1'b0;
    end else if (wrLow && regWrData[CLEAR_TOGGLE_BIT]) begin
      dataToggle_reg <= 1'b0;
    end else if (acceptPacket && !isoMode_reg && dataToggleIn == dataToggle_reg) begin
      dataToggle_reg <= ~dataToggle_reg;
    end
  end
  assign dataToggle = dataToggle_reg;

  // Field words are built apart from the read register so that the read path is
  // one flat multiplexer. Clear-toggle is a strobe and always reads zero.
  assign countHighBits = curCount[COUNT_W-1:COUNT_LOW_W];

  always_comb begin
    ctrlLowWord = REG_RESET;
    ctrlLowWord[READY_BIT] = packetReady_reg;
    ctrlLowWord[FULL_BIT] = fifoFull;
    ctrlLowWord[OVERRUN_BIT] = overrun_reg && isoMode_reg;
    ctrlLowWord[DATA_ERROR_BIT] = curError && packetReady_reg;
    ctrlLowWord[FLUSH_BIT] = flush_reg;
    ctrlLowWord[SEND_STALL_BIT] = sendStall_reg;
    ctrlLowWord[STALL_SENT_BIT] = stallSent_reg;
    ctrlLowWord[CLEAR_TOGGLE_BIT] = 1'b0;
  end

  always_comb begin
    ctrlHighWord = REG_RESET;
    ctrlHighWord[ISO_BIT] = isoMode_reg;
    ctrlHighWord[DOUBLE_BUF_BIT] = doubleBuf_reg;
  end

  // The count only means something while a packet is ready, so it reads zero otherwise.
  always_comb begin
    countLowWord = REG_RESET;
    countHighWord = REG_RESET;
    if (packetReady_reg) begin
      countLowWord = curCount[COUNT_LOW_W-1:0];
      countHighWord[COUNT_HIGH_W-1:0] = countHighBits;
    end
  end

  // Isochronous transfers carry no handshake, so they always show HS_NONE.
  // A bulk packet that cannot be stored is refused with NAK, unless stalled, so that the host retries.
  always_comb begin
    if (!packetDone || isoMode_reg) begin
      handshake = HS_NONE;
    end else if (stallActive) begin
      handshake = HS_STALL;
    end else if (fifoFull || packetError) begin
      handshake = HS_NAK;
    end else begin
      handshake = HS_ACK;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      intPulse <= 1'b0;
    end else begin
      intPulse <= intEnable && (intReady || intOverrun || intStall);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdData_reg <= REG_RESET;
    end else if (regRead) begin
      case (regAddr)
        CTRL_LOW_OFF: begin
          rdData_reg <= ctrlLowWord;
        end
        CTRL_HIGH_OFF: begin
          rdData_reg <= ctrlHighWord;
        end
        COUNT_LOW_OFF: begin
          rdData_reg <= countLowWord;
        end
        COUNT_HIGH_OFF: begin
          rdData_reg <= countHighWord;
        end
        default: begin
          rdData_reg <= REG_RESET;
        end
      endcase
    end
  end
  assign regRdData = rdData_reg;
endmodule : usb_out_endpoint_control

// ===== tb/usb_out_asserts.sv
`timescale 1ns/100ps
module usb_out_asserts
  import usb_out_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [usb_out_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic packetDone,
  input wire logic [1:0] handshake,
  input wire logic dataToggle,
  input wire logic fifoPointerReset,
  input wire logic intEnable,
  input wire logic intPulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence rdOf(logic [7:0] a);
    regRead && regAddr == a;
  endsequence
  sequence flushWr;
    regWrite && regAddr == CTRL_LOW_OFF && regWrData[FLUSH_BIT];
  endsequence
  a_int_one_cycle: assert property (intPulse |=> !intPulse)
    else $error("interrupt pulse longer than one cycle");
  a_int_gated: assert property (!intEnable [*2] |-> !intPulse)
    else $error("interrupt while disabled");
  a_toggle_clear: assert property (regWrite && regAddr == CTRL_LOW_OFF
    && regWrData[CLEAR_TOGGLE_BIT] && !packetDone |=> !dataToggle)
    else $error("toggle not cleared");
  a_toggle_reads_zero: assert property (rdOf(CTRL_LOW_OFF) |=> !regRdData[7])
    else $error("clear toggle read back as one");
  a_high_unused: assert property (rdOf(CTRL_HIGH_OFF) |=> regRdData[5:0] == 6'h00)
    else $error("unused control bits not zero");
  a_count_unused: assert property (rdOf(COUNT_HIGH_OFF) |=> regRdData[7:2] == 6'h00)
    else $error("unused count bits not zero");
  a_unmapped_zero: assert property (regRead && (regAddr < CTRL_LOW_OFF
    || regAddr > COUNT_HIGH_OFF) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_flush_pointer: assert property (flushWr |-> ##[0:2] fifoPointerReset)
    else $error("flush without pointer reset");
  a_idle_handshake: assert property (!packetDone |-> handshake == HS_NONE)
    else $error("handshake without packet");
endmodule : usb_out_asserts

// ===== tb/usb_host_model.sv
`timescale 1ns/100ps
module usb_host_model (
  input wire logic clock,
  input wire logic [1:0] handshake,
  output logic packetDone,
  output logic [9:0] packetCount,
  output logic packetError,
  output logic outToken,
  output logic dataToggleIn
);
  initial begin
    packetDone = 1'b0;
    packetCount = 10'h000;
    packetError = 1'b0;
    outToken = 1'b0;
    dataToggleIn = 1'b0;
  end
  // One token then one data packet; a frame holds at most one such pair.
  task automatic send(input logic [9:0] c, input logic e, output logic [1:0] hs);
    @(posedge clock);
    outToken <= 1'b1;
    @(posedge clock);
    outToken <= 1'b0;
    packetDone <= 1'b1;
    packetCount <= c;
    packetError <= e;
    #1 hs = handshake;
    @(posedge clock);
    packetDone <= 1'b0;
    // Released fields must not keep their last value.
    packetCount <= ~c;
    packetError <= ~e;
  endtask : send
endmodule : usb_host_model

// ===== tb/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin failCount++; \
  $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module tb;
  import usb_out_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0, intEnable = 1'b1;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
  logic packetDone, packetError, outToken, dataToggleIn, dataToggle, intPulse, releasePacket;
  logic [9:0] packetCount;
  logic [1:0] handshake, hs;
  int failCount = 0, samplesChecked = 0, intCount = 0, relCount = 0;
  always #10 clock = ~clock;
  // Counting on the falling edge keeps the counters clear of checks made at rising edges.
  always @(negedge clock) if (intPulse === 1'b1) intCount++;
  always @(negedge clock) if (releasePacket === 1'b1) relCount++;
  usb_out_endpoint_control i_dut (.clock(clock), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .packetDone(packetDone), .packetCount(packetCount), .packetError(packetError),
    .outToken(outToken), .dataToggleIn(dataToggleIn), .handshake(handshake),
    .dataToggle(dataToggle), .fifoPointerReset(), .releasePacket(releasePacket),
    .intEnable(intEnable),
    .intPulse(intPulse));
  usb_host_model i_host (.clock(clock), .handshake(handshake), .packetDone(packetDone),
    .packetCount(packetCount), .packetError(packetError), .outToken(outToken),
    .dataToggleIn(dataToggleIn));
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 `CHK(regRdData, e)
  endtask : rd
  task automatic t_reset_and_bulk();
    for (int a = 8'h13; a <= 8'h18; a++) rd(8'(a), REG_RESET);
    i_host.send(10'h2A5, 1'b0, hs);
    `CHK(hs, HS_ACK)
    repeat (2) @(posedge clock);
    `CHK(intCount, 1)
    rd(CTRL_LOW_OFF, 8'h03);
    rd(COUNT_LOW_OFF, 8'hA5);
    rd(COUNT_HIGH_OFF, 8'h02);
    `CHK(dataToggle, 1'b1)
    wr(CTRL_LOW_OFF, 8'h81);
    rd(CTRL_LOW_OFF, 8'h03);
    `CHK(dataToggle, 1'b0)
    wr(CTRL_LOW_OFF, 8'h00);
    rd(COUNT_LOW_OFF, 8'h00);
    i_host.send(10'h001, 1'b1, hs);
    `CHK(hs, HS_NAK)
  endtask : t_reset_and_bulk
  // Double buffering stays on for isochronous traffic, as firmware is advised to do.
  task automatic t_iso_double();
    wr(CTRL_HIGH_OFF, 8'hC0);
    rd(CTRL_HIGH_OFF, 8'hC0);
    i_host.send(10'h010, 1'b0, hs);
    `CHK(hs, HS_NONE)
    i_host.send(10'h020, 1'b1, hs);
    rd(CTRL_LOW_OFF, 8'h03);
    wr(CTRL_LOW_OFF, 8'h00);
    repeat (3) @(posedge clock);
    `CHK(intCount, 3)
    rd(CTRL_LOW_OFF, 8'h09);
    rd(COUNT_LOW_OFF, 8'h20);
    i_host.send(10'h030, 1'b0, hs);
    i_host.send(10'h040, 1'b0, hs);
    rd(CTRL_LOW_OFF, 8'h0F);
    wr(CTRL_LOW_OFF, 8'h05);
    rd(CTRL_LOW_OFF, 8'h0F);
    wr(CTRL_LOW_OFF, 8'h01);
    rd(CTRL_LOW_OFF, 8'h0B);
    wr(CTRL_LOW_OFF, 8'h00);
    repeat (3) @(posedge clock);
    rd(CTRL_LOW_OFF, 8'h01);
    wr(CTRL_LOW_OFF, 8'h00);
    rd(CTRL_LOW_OFF, 8'h00);
  endtask : t_iso_double
  task automatic t_stall_flush();
    wr(CTRL_LOW_OFF, 8'h20);
    i_host.send(10'h005, 1'b0, hs);
    `CHK(hs, HS_NONE)
    rd(CTRL_LOW_OFF, 8'h21);
    wr(CTRL_LOW_OFF, 8'h20);
    wr(CTRL_HIGH_OFF, 8'h00);
    i_host.send(10'h005, 1'b0, hs);
    `CHK(hs, HS_STALL)
    rd(CTRL_LOW_OFF, 8'h60);
    wr(CTRL_LOW_OFF, 8'h00);
    rd(CTRL_LOW_OFF, 8'h00);
    intEnable <= 1'b0;
    i_host.send(10'h007, 1'b0, hs);
    repeat (2) @(posedge clock);
    d = 8'(intCount);
    wr(CTRL_LOW_OFF, 8'h11);
    rd(CTRL_LOW_OFF, 8'h00);
    `CHK(8'(intCount), d)
    `CHK(relCount, 6)
  endtask : t_stall_flush
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    t_reset_and_bulk();
    t_iso_double();
    t_stall_flush();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clock);
    failCount++;
    final_report();
  end
endmodule : tb
bind usb_out_endpoint_control usb_out_asserts i_chk (.clock(clock), .nrst(nrst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .packetDone(packetDone), .handshake(handshake),
  .dataToggle(dataToggle), .fifoPointerReset(fifoPointerReset), .intEnable(intEnable),
  .intPulse(intPulse));
